// ===== shared/bridge_window_pkg.sv
// Constants for the bridge memory forwarding window registers.
// Assumes dword configuration accesses with byte enables from the primary side.
package bridge_window_pkg;

	// ==========================================
	// Configuration offsets (byte addresses)
	localparam logic [7:0]  MEM_BOTTOM_OFS      = 8'h20;
	localparam logic [7:0]  MEM_TOP_OFS         = 8'h22;
	localparam logic [7:0]  PF_BOTTOM_OFS       = 8'h24;
	localparam logic [7:0]  PF_TOP_OFS          = 8'h26;
	localparam logic [7:0]  PF_BOTTOM_HIGH_OFS  = 8'h28;
	localparam logic [7:0]  PF_TOP_HIGH_OFS     = 8'h2C;

	// ==========================================
	// Field layout
	localparam int          ADDR_FIELD_LSB      = 4;
	localparam int          ADDR_FIELD_W        = 12;
	localparam int          WINDOW_LOW_W        = 20;
	localparam logic [3:0]  RESERVED_NIBBLE     = 4'h0;
	localparam logic [3:0]  WIDE_ADDRESS_IND    = 4'h1;
	localparam logic [19:0] WINDOW_LOW_ZEROS    = 20'h00000;
	localparam logic [19:0] WINDOW_LOW_ONES     = 20'hFFFFF;

	// ==========================================
	// Reset values
	localparam logic [15:0] MEM_BOTTOM_RESET    = 16'h0000;
	localparam logic [15:0] MEM_TOP_RESET       = 16'h0000;
	localparam logic [15:0] PF_BOTTOM_RESET     = 16'h0001;
	localparam logic [15:0] PF_TOP_RESET        = 16'h0001;
	localparam logic [31:0] PF_HIGH_RESET       = 32'h00000000;
	localparam logic [31:0] UNMAPPED_READ       = 32'h00000000;

endpackage : bridge_window_pkg

// ===== src/window_match.sv
// Inclusive range compare of an address against a bottom and a top bound.
// Assumes bounds are stable registers; purely combinational.
`timescale 1ns/10ps
`default_nettype none

module window_match #(
	parameter int WIDTH = 64
) (
	input  wire logic [WIDTH-1:0] addr,
	input  wire logic [WIDTH-1:0] bottom,
	input  wire logic [WIDTH-1:0] top,
	output logic                  hit
);

	// An inverted window (top below bottom) never matches
	assign hit = (addr >= bottom) && (addr <= top);

endmodule : window_match

`default_nettype wire

// ===== src/bridge_memory_window_regs.sv
// Memory forwarding window registers of a bridge and the downstream decode.
// Assumes same-clock configuration requests with byte enables and a
// transaction address presented for one cycle with txn_valid.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - A 16-bit writable register holds address bits 31:20 of the top of the plain memory window, reset zero.
// - The top of either window takes its low 20 address bits as all ones.
// - Bits 3:0 of the plain window top register read zero and ignore writes.
// - The prefetch bottom register holds address bits 31:20 of the prefetch bottom, low 20 bits zero.
// - The prefetch top register holds address bits 31:20 of the prefetch window top.
// - Bits 3:0 of both prefetch bound registers are read-only one, and both reset to one.
// - A separate register gives address bits 63:32 of the prefetch bottom for a 64-bit compare.
// - A separate register gives address bits 63:32 of the prefetch top.
// - The prefetch bottom upper half is fully writable over 31:0 and resets to zero.
// - The plain window bottom comes from bits 15:4 at offset 20h, low 20 bits zero.
module bridge_memory_window_regs (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        cfg_wr_en,
	input  wire logic        cfg_rd_en,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	output logic             cfg_rd_ack,
	input  wire logic        txn_valid,
	input  wire logic [63:0] txn_addr,
	output logic             decode_valid,
	output logic             decode_forward,
	output logic             decode_prefetch
);

	// ==========================================
	// Storage
	logic [11:0] mem_bottom_reg;
	logic [11:0] memory_window_top_bits_reg;
	logic [11:0] prefetch_window_bottom_bits_reg;
	logic [11:0] prefetch_window_top_bits_reg;
	logic [31:0] pf_bottom_high_reg;
	logic [31:0] pf_top_high_reg;
	logic [5:0]  dword;
	logic        wr_lo20;
	logic        wr_lo24;
	logic        wr_28;
	logic        wr_2c;
	logic [15:0] mem_bottom_view;
	logic [15:0] mem_top_view;
	logic [15:0] pf_bottom_view;
	logic [15:0] pf_top_view;
	logic [31:0] rdata_next;
	logic [63:0] mem_lo;
	logic [63:0] mem_hi;
	logic [63:0] pf_lo;
	logic [63:0] pf_hi;
	logic        mem_hit;
	logic        pf_hit;

	// Byte lanes 1:0 reach field bits 11:4 and 3:0 of a 16-bit bound
	function automatic logic [11:0] lane_update(
		input logic [11:0] old,
		input logic [15:0] d,
		input logic [1:0]  be
	);
		lane_update = {be[1] ? d[15:8] : old[11:4], be[0] ? d[7:4] : old[3:0]};
	endfunction : lane_update

	function automatic logic [31:0] word_update(
		input logic [31:0] old,
		input logic [31:0] d,
		input logic [3:0]  be
	);
		word_update = {be[3] ? d[31:24] : old[31:24], be[2] ? d[23:16] : old[23:16],
			be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction : word_update

	// ==========================================
	// Address decode
	assign dword   = cfg_addr[7:2];
	assign wr_lo20 = cfg_wr_en && (dword == bridge_window_pkg::MEM_BOTTOM_OFS[7:2]);
	assign wr_lo24 = cfg_wr_en && (dword == bridge_window_pkg::PF_BOTTOM_OFS[7:2]);
	assign wr_28   = cfg_wr_en && (dword == bridge_window_pkg::PF_BOTTOM_HIGH_OFS[7:2]);
	assign wr_2c   = cfg_wr_en && (dword == bridge_window_pkg::PF_TOP_HIGH_OFS[7:2]);

	// ==========================================
	// Plain memory window
	// base bits writes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_bottom_reg <= bridge_window_pkg::MEM_BOTTOM_RESET[15:4];
		end else if (wr_lo20) begin
			mem_bottom_reg <= lane_update(mem_bottom_reg, cfg_wdata[15:0], cfg_be[1:0]);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			memory_window_top_bits_reg <= bridge_window_pkg::MEM_TOP_RESET[15:4];
		end else if (wr_lo20) begin
			memory_window_top_bits_reg <= lane_update(memory_window_top_bits_reg,
				cfg_wdata[31:16], cfg_be[3:2]);
		end
	end

	// ==========================================
	// Prefetchable window
	// bottom bits writes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prefetch_window_bottom_bits_reg <= bridge_window_pkg::PF_BOTTOM_RESET[15:4];
		end else if (wr_lo24) begin
			prefetch_window_bottom_bits_reg <= lane_update(prefetch_window_bottom_bits_reg,
				cfg_wdata[15:0], cfg_be[1:0]);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prefetch_window_top_bits_reg <= bridge_window_pkg::PF_TOP_RESET[15:4];
		end else if (wr_lo24) begin
			prefetch_window_top_bits_reg <= lane_update(prefetch_window_top_bits_reg,
				cfg_wdata[31:16], cfg_be[3:2]);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pf_bottom_high_reg <= bridge_window_pkg::PF_HIGH_RESET;
		end else if (wr_28) begin
			pf_bottom_high_reg <= word_update(pf_bottom_high_reg, cfg_wdata, cfg_be);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pf_top_high_reg <= bridge_window_pkg::PF_HIGH_RESET;
		end else if (wr_2c) begin
			pf_top_high_reg <= word_update(pf_top_high_reg, cfg_wdata, cfg_be);
		end
	end

	// ==========================================
	// Read-back
	// reserved nibble reads zero
	assign mem_bottom_view = {mem_bottom_reg, bridge_window_pkg::RESERVED_NIBBLE};
	assign mem_top_view    = {memory_window_top_bits_reg, bridge_window_pkg::RESERVED_NIBBLE};
	assign pf_bottom_view  = {prefetch_window_bottom_bits_reg, bridge_window_pkg::WIDE_ADDRESS_IND};
	assign pf_top_view     = {prefetch_window_top_bits_reg, bridge_window_pkg::WIDE_ADDRESS_IND};

	always_comb begin
		if (dword == bridge_window_pkg::MEM_BOTTOM_OFS[7:2]) begin
			rdata_next = {mem_top_view, mem_bottom_view};
		end else if (dword == bridge_window_pkg::PF_BOTTOM_OFS[7:2]) begin
			rdata_next = {pf_top_view, pf_bottom_view};
		end else if (dword == bridge_window_pkg::PF_BOTTOM_HIGH_OFS[7:2]) begin
			rdata_next = pf_bottom_high_reg;
		end else if (dword == bridge_window_pkg::PF_TOP_HIGH_OFS[7:2]) begin
			rdata_next = pf_top_high_reg;
		end else begin
			rdata_next = bridge_window_pkg::UNMAPPED_READ;
		end
	end

	// Data is held until the next read so software may sample late
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_rdata  <= bridge_window_pkg::UNMAPPED_READ;
			cfg_rd_ack <= 1'b0;
		end else begin
			cfg_rd_ack <= cfg_rd_en;
			if (cfg_rd_en) begin
				cfg_rdata <= rdata_next;
			end
		end
	end

	// ==========================================
	// Forwarding decode
	// window bounds
	assign mem_lo = {32'h00000000, mem_bottom_reg, bridge_window_pkg::WINDOW_LOW_ZEROS};
	assign mem_hi = {32'h00000000, memory_window_top_bits_reg,
		bridge_window_pkg::WINDOW_LOW_ONES};
	assign pf_lo = {pf_bottom_high_reg, prefetch_window_bottom_bits_reg,
		bridge_window_pkg::WINDOW_LOW_ZEROS};
	assign pf_hi = {pf_top_high_reg, prefetch_window_top_bits_reg,
		bridge_window_pkg::WINDOW_LOW_ONES};

	window_match #(.WIDTH(64)) u_mem_match (
		.addr   (txn_addr),
		.bottom (mem_lo),
		.top    (mem_hi),
		.hit    (mem_hit)
	);

	window_match #(.WIDTH(64)) u_pf_match (
		.addr   (txn_addr),
		.bottom (pf_lo),
		.top    (pf_hi),
		.hit    (pf_hit)
	);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			decode_valid    <= 1'b0;
			decode_forward  <= 1'b0;
			decode_prefetch <= 1'b0;
		end else begin
			decode_valid    <= txn_valid;
			decode_forward  <= txn_valid && (mem_hit || pf_hit);
			decode_prefetch <= txn_valid && pf_hit;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_top_write;
		wr_lo20 && (cfg_be[3:2] == 2'b11)
			|=> memory_window_top_bits_reg == $past(cfg_wdata[31:20]);
	endproperty
	a_top_write: assert property (p_top_write)
		else $error("Plain window top did not take written bits");
	property p_top_reserved;
		cfg_rd_en && (dword == bridge_window_pkg::MEM_BOTTOM_OFS[7:2])
			|=> cfg_rd_ack && (cfg_rdata[19:16] == 4'h0) && (cfg_rdata[3:0] == 4'h0);
	endproperty
	a_top_reserved: assert property (p_top_reserved)
		else $error("Reserved nibble of plain window did not read zero");
	property p_wide_ind;
		cfg_rd_en && (dword == bridge_window_pkg::PF_BOTTOM_OFS[7:2])
			|=> (cfg_rdata[3:0] == 4'h1) && (cfg_rdata[19:16] == 4'h1);
	endproperty
	a_wide_ind: assert property (p_wide_ind)
		else $error("Prefetch bound low nibble did not read one");
	property p_pf_top_write;
		wr_lo24 && (cfg_be[3:2] == 2'b11)
			|=> prefetch_window_top_bits_reg == $past(cfg_wdata[31:20]);
	endproperty
	a_pf_top_write: assert property (p_pf_top_write)
		else $error("Prefetch top did not take written bits");
	property p_high_write;
		wr_28 && (cfg_be == 4'hF) |=> pf_bottom_high_reg == $past(cfg_wdata);
	endproperty
	a_high_write: assert property (p_high_write)
		else $error("Prefetch bottom upper half did not take written word");
	property p_top_high_read;
		cfg_rd_en && (dword == bridge_window_pkg::PF_TOP_HIGH_OFS[7:2])
			|=> cfg_rdata == $past(pf_top_high_reg);
	endproperty
	a_top_high_read: assert property (p_top_high_read)
		else $error("Prefetch top upper half read back wrong");
	property p_base_edge;
		txn_valid && (txn_addr == {32'h00000000, mem_bottom_reg, 20'h00000})
			&& (mem_bottom_reg <= memory_window_top_bits_reg) |=> decode_forward;
	endproperty
	a_base_edge: assert property (p_base_edge)
		else $error("Bottom address of plain window not forwarded");
	property p_top_edge;
		txn_valid && (txn_addr == {pf_top_high_reg, prefetch_window_top_bits_reg, 20'hFFFFF})
			&& (pf_lo <= txn_addr) |=> decode_forward && decode_prefetch;
	endproperty
	a_top_edge: assert property (p_top_edge)
		else $error("Top address of prefetch window not forwarded");
	property p_upper_compare;
		txn_valid && (txn_addr[63:32] < pf_bottom_high_reg) && (txn_addr[63:32] != 32'h0)
			|=> !decode_prefetch;
	endproperty
	a_upper_compare: assert property (p_upper_compare)
		else $error("Address below prefetch upper bound was claimed");
	property p_outside;
		txn_valid && ((txn_addr < mem_lo) || (txn_addr > mem_hi))
			&& ((txn_addr < pf_lo) || (txn_addr > pf_hi)) |=> !decode_forward ##1 1'b1;
	endproperty
	a_outside: assert property (p_outside)
		else $error("Address outside both windows was forwarded");
	property p_pf_bottom_write;
		wr_lo24 && (cfg_be[1:0] == 2'b11)
			|=> prefetch_window_bottom_bits_reg == $past(cfg_wdata[15:4]);
	endproperty
	a_pf_bottom_write: assert property (p_pf_bottom_write)
		else $error("Prefetch bottom did not take written bits");

endmodule : bridge_memory_window_regs

`default_nettype wire

// ===== verif/host_model.sv
// Host model: issues configuration and memory transaction requests.
// Assumes the bench calls its tasks; inputs change on falling edges.
`timescale 1ns/10ps
`default_nettype none

module host_model (
	input  wire logic        clk,
	output logic             cfg_wr_en,
	output logic             cfg_rd_en,
	output logic      [7:0]  cfg_addr,
	output logic      [3:0]  cfg_be,
	output logic      [31:0] cfg_wdata,
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_rd_ack,
	output logic             txn_valid,
	output logic      [63:0] txn_addr,
	input  wire logic        decode_valid,
	input  wire logic        decode_forward,
	input  wire logic        decode_prefetch
);
	// ==========================================
	// Requests
	initial begin
		cfg_wr_en = 1'b0;
		cfg_rd_en = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
		txn_valid = 1'b0;
		txn_addr = 64'h0;
	end

	// Released lines show the inverse so stale data cannot pass
	task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(negedge clk);
		cfg_addr = a;
		cfg_be = b;
		cfg_wdata = d;
		cfg_wr_en = 1'b1;
		@(negedge clk);
		cfg_wr_en = 1'b0;
		cfg_wdata = ~d;
	endtask : cfg_write

	task automatic cfg_read(input logic [7:0] a, output logic [31:0] q, output logic ack);
		@(negedge clk);
		cfg_addr = a;
		cfg_rd_en = 1'b1;
		@(negedge clk);
		// Acknowledge stands only for the cycle after the taking edge
		ack = cfg_rd_ack;
		q = cfg_rdata;
		cfg_rd_en = 1'b0;
		cfg_addr = ~a;
	endtask : cfg_read

	task automatic send_txn(input logic [63:0] a, output logic [2:0] r);
		@(negedge clk);
		txn_addr = a;
		txn_valid = 1'b1;
		@(negedge clk);
		// Decode result follows txn_valid by one cycle and stands for one
		r = {decode_valid, decode_forward, decode_prefetch};
		txn_valid = 1'b0;
		txn_addr = ~a;
	endtask : send_txn
endmodule : host_model

`default_nettype wire

// ===== verif/bridge_memory_window_regs_test.sv
// Self-checking bench for the memory window registers and decode.
// Assumes host_model drives every request of the block.
`timescale 1ns/10ps
`default_nettype none

module bridge_memory_window_regs_test;
	logic        clk;
	logic        rst_b;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  addr;
	logic [3:0]  be;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        rd_ack;
	logic        tv;
	logic [63:0] ta;
	logic        dv;
	logic        df;
	logic        dp;
	int          err_count = 0;
	int          num_checks = 0;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	host_model u_host_model (.clk(clk), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en), .cfg_addr(addr),
		.cfg_be(be), .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_rd_ack(rd_ack), .txn_valid(tv),
		.txn_addr(ta), .decode_valid(dv), .decode_forward(df), .decode_prefetch(dp));

	bridge_memory_window_regs u_bridge_memory_window_regs (.clk(clk), .rst_b(rst_b),
		.cfg_wr_en(wr_en), .cfg_rd_en(rd_en), .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata),
		.cfg_rdata(rdata), .cfg_rd_ack(rd_ack), .txn_valid(tv), .txn_addr(ta),
		.decode_valid(dv), .decode_forward(df), .decode_prefetch(dp));

	// ==========================================
	// Helpers
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		u_host_model.cfg_write(a, b, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        k;
		u_host_model.cfg_read(a, q, k);
		check("read ack", {63'h0, k}, 64'h1);
		check("read data", {32'h0, q}, {32'h0, exp});
	endtask : rd

	task automatic dec(input logic [63:0] a, input logic f, input logic p);
		logic [2:0] r;
		u_host_model.send_txn(a, r);
		check("decode", {61'h0, r}, {61'h0, 1'b1, f, p});
	endtask : dec

	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// ==========================================
	// Scenarios
	task automatic test_reset_values;
		rd(8'h20, 32'h00000000);
		rd(8'h24, 32'h00010001);
		rd(8'h28, 32'h00000000);
		rd(8'h2C, 32'h00000000);
		rd(8'h30, 32'h00000000);
	endtask : test_reset_values

	task automatic test_field_access;
		wr(8'h20, 4'hC, 32'h12300000);
		rd(8'h20, 32'h12300000);
		wr(8'h20, 4'hF, 32'hFFFFFFFF);
		rd(8'h20, 32'hFFF0FFF0);
		wr(8'h24, 4'hF, 32'hFFFFFFFF);
		rd(8'h24, 32'hFFF1FFF1);
		wr(8'h24, 4'hF, 32'h00000000);
		rd(8'h24, 32'h00010001);
		wr(8'h28, 4'hF, 32'hFFFFFFFF);
		wr(8'h28, 4'h2, 32'h00001200);
		rd(8'h28, 32'hFFFF12FF);
		wr(8'h2C, 4'hF, 32'hA5A55A5A);
		rd(8'h2C, 32'hA5A55A5A);
		wr(8'h30, 4'hF, 32'hFFFFFFFF);
		rd(8'h30, 32'h00000000);
	endtask : test_field_access

	// Prefetch window left with top below bottom so it never hits here
	task automatic test_plain_decode;
		wr(8'h20, 4'hF, 32'h1FF01000);
		wr(8'h2C, 4'hF, 32'h00000000);
		dec(64'h0FFFFFFF, 1'b0, 1'b0);
		dec(64'h10000000, 1'b1, 1'b0);
		dec(64'h1FFFFFFF, 1'b1, 1'b0);
		dec(64'h20000000, 1'b0, 1'b0);
		dec(64'h110000000, 1'b0, 1'b0);
	endtask : test_plain_decode

	task automatic test_prefetch_decode;
		wr(8'h24, 4'hF, 32'h3FF03000);
		wr(8'h28, 4'hF, 32'h00000001);
		wr(8'h2C, 4'hF, 32'h00000001);
		dec(64'h12FFFFFFF, 1'b0, 1'b0);
		dec(64'h130000000, 1'b1, 1'b1);
		dec(64'h030000000, 1'b0, 1'b0);
		dec(64'h13FFFFFFF, 1'b1, 1'b1);
		dec(64'h140000000, 1'b0, 1'b0);
		dec(64'h018000000, 1'b1, 1'b0);
		wr(8'h2C, 4'hF, 32'h00000002);
		dec(64'h140000000, 1'b1, 1'b1);
	endtask : test_prefetch_decode

	// Second reset mid-run must bring every bound back to its reset value
	task automatic test_mid_reset;
		@(negedge clk);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		test_reset_values();
		dec(64'h00000000, 1'b1, 1'b1);
		dec(64'h00100000, 1'b0, 1'b0);
	endtask : test_mid_reset

	// ==========================================
	// Sequence and watchdog
	initial begin
		rst_b = 1'b0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		test_reset_values();
		test_field_access();
		test_plain_decode();
		test_prefetch_decode();
		test_mid_reset();
		finish_test();
	end

	// About 100 cycles expected; wide margin
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		finish_test();
	end
endmodule : bridge_memory_window_regs_test

`default_nettype wire
